// ---- fws_apb_slave.sv ----
`timescale 1ns/1ns
`include "fws_params.svh"

module fws_apb_slave
   import fws_pkg::*;
(
   input  wire logic [`FWS_APB_AW-1:0] i_paddr,
   input  wire logic                   i_psel,
   input  wire logic                   i_penable,
   input  wire logic                   i_pwrite,
   output fws_sel_e                    o_sel,
   output logic                        o_setup_rd,
   output logic                        o_access_wr,
   output logic                        o_pready,
   output logic                        o_pslverr
);

   // ****************************************
   // Address decode
   // ****************************************
   function automatic fws_sel_e decode(input logic [`FWS_APB_AW-1:0] addr);
      logic [`FWS_IDX_W-1:0] idx;
      idx = addr[`FWS_APB_AW-1:2];
      decode = FWS_SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         unique case (idx)
            `FWS_IDX_SECTOR:       decode = FWS_SEL_SECTOR;
            `FWS_IDX_BANK:         decode = FWS_SEL_BANK;
            `FWS_IDX_DATA_EVEN_LO: decode = FWS_SEL_DATA_EVEN_LO;
            `FWS_IDX_DATA_EVEN_HI: decode = FWS_SEL_DATA_EVEN_HI;
            `FWS_IDX_DATA_ODD_LO:  decode = FWS_SEL_DATA_ODD_LO;
            `FWS_IDX_DATA_ODD_HI:  decode = FWS_SEL_DATA_ODD_HI;
            `FWS_IDX_ADDR_LO:      decode = FWS_SEL_ADDR_LO;
            `FWS_IDX_ADDR_HI:      decode = FWS_SEL_ADDR_HI;
            `FWS_IDX_IRQ_STATUS:   decode = FWS_SEL_IRQ_STATUS;
            `FWS_IDX_IRQ_ENABLE:   decode = FWS_SEL_IRQ_ENABLE;
            `FWS_IDX_IRQ_CLEAR:    decode = FWS_SEL_IRQ_CLEAR;
            default:               decode = FWS_SEL_NONE;
         endcase
      end
   endfunction

   // Read data is prepared in setup, so the slave never waits
   assign o_sel       = decode(i_paddr);
   assign o_pready    = 1'b1;
   assign o_setup_rd  = i_psel && !i_penable && !i_pwrite;
   assign o_access_wr = i_psel && i_penable && i_pwrite && (o_sel != FWS_SEL_NONE);
   assign o_pslverr   = i_psel && i_penable && (o_sel == FWS_SEL_NONE);

endmodule // fws_apb_slave

// ---- fws_params.svh ----
// Summary of operation
// - During an erase the block itself drives the eight sector bits.
// - A write operation ending without error or suspend clears all eight sector bits.
// - During an erase the block updates the bank flag at bit 8.
// - An erase ending without error or suspend clears the bank flag.
// - Flag set means erase error if error flag, else suspended if suspend flag.
// - A sector erase erases only the selected sectors of the bank.
`ifndef FWS_PARAMS_SVH
`define FWS_PARAMS_SVH

// ****************************************
// Bus geometry
// ****************************************
`define FWS_APB_AW             24
`define FWS_IDX_W              22
`define FWS_REG_W              16

// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define FWS_IDX_SECTOR         22'h080004
`define FWS_IDX_BANK           22'h080006
`define FWS_IDX_DATA_EVEN_LO   22'h080008
`define FWS_IDX_DATA_EVEN_HI   22'h08000A
`define FWS_IDX_DATA_ODD_LO    22'h08000C
`define FWS_IDX_DATA_ODD_HI    22'h08000E
`define FWS_IDX_ADDR_LO        22'h080010
`define FWS_IDX_ADDR_HI        22'h080012
`define FWS_IDX_IRQ_STATUS     22'h080014
`define FWS_IDX_IRQ_ENABLE     22'h080016
`define FWS_IDX_IRQ_CLEAR      22'h080018

// ****************************************
// Reset values
// ****************************************
`define FWS_RST_DATA           16'hFFFF
`define FWS_RST_ADDR_LO        14'h0000
`define FWS_RST_ADDR_HI        5'h00
`define FWS_RST_SECTOR         8'h00
`define FWS_RST_IRQ            3'h0

// ****************************************
// Field layout
// ****************************************
`define FWS_SECTORS            8
`define FWS_BANK_FLAG_BIT      8
`define FWS_ADDR_LO_LSB        2
`define FWS_ADDR_LO_W          14
`define FWS_ADDR_HI_W          5
`define FWS_TARGET_W           21
`define FWS_IRQ_W              3
`define FWS_IRQ_DONE           0
`define FWS_IRQ_FAIL           1
`define FWS_IRQ_SUSPEND_FLAG           2

`endif

// ---- fws_pkg.sv ----
package fws_pkg;

   typedef enum logic [1:0] {
      FWS_PH_IDLE  = 2'b00,
      FWS_PH_WRITE = 2'b01,
      FWS_PH_ERASE = 2'b10
   } fws_phase_e;

   typedef enum logic [1:0] {
      FWS_FLAG_NONE      = 2'b00,
      FWS_FLAG_ERROR     = 2'b01,
      FWS_FLAG_SUSPENDED = 2'b10
   } fws_meaning_e;

   typedef enum logic [3:0] {
      FWS_SEL_NONE        = 4'h0,
      FWS_SEL_SECTOR      = 4'h1,
      FWS_SEL_BANK        = 4'h2,
      FWS_SEL_DATA_EVEN_LO = 4'h3,
      FWS_SEL_DATA_EVEN_HI = 4'h4,
      FWS_SEL_DATA_ODD_LO = 4'h5,
      FWS_SEL_DATA_ODD_HI = 4'h6,
      FWS_SEL_ADDR_LO     = 4'h7,
      FWS_SEL_ADDR_HI     = 4'h8,
      FWS_SEL_IRQ_STATUS  = 4'h9,
      FWS_SEL_IRQ_ENABLE  = 4'hA,
      FWS_SEL_IRQ_CLEAR   = 4'hB
   } fws_sel_e;

endpackage

// ---- fws_status_track.sv ----
`timescale 1ns/1ns
`include "fws_params.svh"

module fws_status_track
   import fws_pkg::*;
(
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_rst,
   input  wire logic                    i_sw_wr_sector,
   input  wire logic [`FWS_SECTORS-1:0] i_sw_sector,
   input  wire logic                    i_write_busy,
   input  wire logic                    i_erase_op,
   input  wire logic                    i_err_flag,
   input  wire logic                    i_suspend_flag_flag,
   input  wire logic [`FWS_SECTORS-1:0] i_hw_sector,
   input  wire logic                    i_hw_bank,
   output logic [`FWS_SECTORS-1:0]      o_sector,
   output logic                         o_bank,
   output fws_meaning_e                 o_meaning,
   output logic                         o_done,
   output logic                         o_fail,
   output logic                         o_suspend_flag
);

   fws_phase_e                 phase_q, phase_d;
   logic [`FWS_SECTORS-1:0]    sector_q, sector_d;
   logic                       bank_q, bank_d;
   fws_meaning_e               meaning_q, meaning_d;
   logic                       done_q, done_d;
   logic                       fail_q, fail_d;
   logic                       suspend_flag_q, suspend_flag_d;
   logic                       end_op;

   // ****************************************
   // Operation phase and flags
   // ****************************************
   always_comb begin
      phase_d  = phase_q;
      sector_d = sector_q;
      bank_d   = bank_q;
      done_d   = 1'b0;
      fail_d   = 1'b0;
      suspend_flag_d   = 1'b0;
      end_op   = (phase_q != FWS_PH_IDLE) && !i_write_busy;
      if (i_sw_wr_sector) begin
         sector_d = i_sw_sector;
      end
      unique case (phase_q)
         FWS_PH_IDLE: begin
            if (i_write_busy) begin
               phase_d = i_erase_op ? FWS_PH_ERASE : FWS_PH_WRITE;
            end
         end
         FWS_PH_WRITE: ;
         FWS_PH_ERASE: begin
            sector_d = i_hw_sector;
            bank_d   = i_hw_bank;
         end
         default: begin
            phase_d = FWS_PH_IDLE;
         end
      endcase
      if (end_op) begin
         phase_d = FWS_PH_IDLE;
         if (i_suspend_flag_flag) begin
            suspend_flag_d = 1'b1;
         end else if (i_err_flag) begin
            fail_d = 1'b1;
         end else begin
            done_d   = 1'b1;
            sector_d = '0;
            if (phase_q == FWS_PH_ERASE) begin
               bank_d = 1'b0;
            end
         end
      end
      if (i_err_flag) begin
         meaning_d = FWS_FLAG_ERROR;
      end else if (i_suspend_flag_flag) begin
         meaning_d = FWS_FLAG_SUSPENDED;
      end else begin
         meaning_d = FWS_FLAG_NONE;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         phase_q   <= FWS_PH_IDLE;
         sector_q  <= `FWS_RST_SECTOR;
         bank_q    <= 1'b0;
         meaning_q <= FWS_FLAG_NONE;
         done_q    <= 1'b0;
         fail_q    <= 1'b0;
         suspend_flag_q    <= 1'b0;
      end else begin
         phase_q   <= phase_d;
         sector_q  <= sector_d;
         bank_q    <= bank_d;
         meaning_q <= meaning_d;
         done_q    <= done_d;
         fail_q    <= fail_d;
         suspend_flag_q    <= suspend_flag_d;
      end
   end

   assign o_sector  = sector_q;
   assign o_bank    = bank_q;
   assign o_meaning = meaning_q;
   assign o_done    = done_q;
   assign o_fail    = fail_q;
   assign o_suspend_flag    = suspend_flag_q;

endmodule // fws_status_track

// ---- fws_top.sv ----
// Local design decision: the APB register port.
`timescale 1ns/1ns
`include "fws_params.svh"

module fws_top
   import fws_pkg::*;
(
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_rst,
   // APB slave
   input  wire logic [`FWS_APB_AW-1:0]  i_paddr,
   input  wire logic                    i_psel,
   input  wire logic                    i_penable,
   input  wire logic                    i_pwrite,
   input  wire logic [31:0]             i_pwdata,
   input  wire logic [3:0]              i_pstrb,
   output logic [31:0]                  o_prdata,
   output logic                         o_pready,
   output logic                         o_pslverr,
   // From the write controller
   input  wire logic                    i_write_busy,
   input  wire logic                    i_erase_op,
   input  wire logic                    i_err_flag,
   input  wire logic                    i_suspend_flag_flag,
   input  wire logic [`FWS_SECTORS-1:0] i_hw_sector,
   input  wire logic                    i_hw_bank,
   // To the write controller
   output logic [`FWS_SECTORS-1:0]      o_sector_select,
   output logic                         o_bank_flag,
   output logic [31:0]                  o_data_even,
   output logic [31:0]                  o_data_odd,
   output logic [`FWS_TARGET_W-1:0]     o_target_addr,
   output logic                         o_erase_error,
   output logic                         o_erase_suspended,
   // Interrupt
   output logic                         o_irq
);

   // ****************************************
   // Declarations
   // ****************************************
   fws_sel_e                    sel;
   logic                        setup_rd;
   logic                        access_wr;
   logic [`FWS_SECTORS-1:0]     sector_flags;
   logic                        bank_flag;
   fws_meaning_e                meaning;
   logic                        ev_done;
   logic                        ev_fail;
   logic                        ev_suspend_flag;
   logic                        sw_wr_sector;

   logic [`FWS_REG_W-1:0]       even_lo_q, even_lo_d;
   logic [`FWS_REG_W-1:0]       even_hi_q, even_hi_d;
   logic [`FWS_REG_W-1:0]       odd_lo_q, odd_lo_d;
   logic [`FWS_REG_W-1:0]       odd_hi_q, odd_hi_d;
   logic [`FWS_ADDR_LO_W-1:0]   addr_lo_q, addr_lo_d;
   logic [`FWS_ADDR_HI_W-1:0]   addr_hi_q, addr_hi_d;
   logic [`FWS_IRQ_W-1:0]       irq_stat_q, irq_stat_d;
   logic [`FWS_IRQ_W-1:0]       irq_en_q, irq_en_d;
   logic [31:0]                 prdata_q, prdata_d;
   logic [`FWS_REG_W-1:0]       wr16;
   logic [`FWS_IRQ_W-1:0]       irq_events;

   // ****************************************
   // Helpers
   // ****************************************
   // Byte-lane merge of the low half-word under the strobes
   function automatic logic [`FWS_REG_W-1:0] merge16(
      input logic [`FWS_REG_W-1:0] old_val,
      input logic [31:0]           wdata,
      input logic [3:0]            strb
   );
      merge16[7:0]  = strb[0] ? wdata[7:0]  : old_val[7:0];
      merge16[15:8] = strb[1] ? wdata[15:8] : old_val[15:8];
   endfunction

   // Zero-extend a half-word into a bus word
   function automatic logic [31:0] word16(input logic [`FWS_REG_W-1:0] val);
      word16 = {16'h0000, val};
   endfunction

   // ****************************************
   // Bus slave
   // ****************************************
   fws_apb_slave u_apb (
      .i_paddr     (i_paddr),
      .i_psel      (i_psel),
      .i_penable   (i_penable),
      .i_pwrite    (i_pwrite),
      .o_sel       (sel),
      .o_setup_rd  (setup_rd),
      .o_access_wr (access_wr),
      .o_pready    (o_pready),
      .o_pslverr   (o_pslverr)
   );

   // ****************************************
   // Sector and bank status
   // ****************************************
   assign sw_wr_sector = access_wr && (sel == FWS_SEL_SECTOR);

   fws_status_track u_track (
      .i_clk_sys      (i_clk_sys),
      .i_rst          (i_rst),
      .i_sw_wr_sector (sw_wr_sector),
      .i_sw_sector    (wr16[`FWS_SECTORS-1:0]),
      .i_write_busy   (i_write_busy),
      .i_erase_op     (i_erase_op),
      .i_err_flag     (i_err_flag),
      .i_suspend_flag_flag    (i_suspend_flag_flag),
      .i_hw_sector    (i_hw_sector),
      .i_hw_bank      (i_hw_bank),
      .o_sector       (sector_flags),
      .o_bank         (bank_flag),
      .o_meaning      (meaning),
      .o_done         (ev_done),
      .o_fail         (ev_fail),
      .o_suspend_flag         (ev_suspend_flag)
   );

   assign wr16 = merge16({8'h00, sector_flags}, i_pwdata, i_pstrb);

   // ****************************************
   // Data and address registers
   // ****************************************
   always_comb begin
      even_lo_d = even_lo_q;
      even_hi_d = even_hi_q;
      odd_lo_d  = odd_lo_q;
      odd_hi_d  = odd_hi_q;
      addr_lo_d = addr_lo_q;
      addr_hi_d = addr_hi_q;
      // only a bus write changes them
      if (access_wr) begin
         unique case (sel)
            FWS_SEL_DATA_EVEN_LO: even_lo_d = merge16(even_lo_q, i_pwdata, i_pstrb);
            FWS_SEL_DATA_EVEN_HI: even_hi_d = merge16(even_hi_q, i_pwdata, i_pstrb);
            FWS_SEL_DATA_ODD_LO:  odd_lo_d  = merge16(odd_lo_q, i_pwdata, i_pstrb);
            FWS_SEL_DATA_ODD_HI:  odd_hi_d  = merge16(odd_hi_q, i_pwdata, i_pstrb);
            // bits 15:2 kept, low two reserved
            FWS_SEL_ADDR_LO: begin
               addr_lo_d = `FWS_ADDR_LO_W'(merge16({addr_lo_q, 2'b00}, i_pwdata, i_pstrb)
                           >> `FWS_ADDR_LO_LSB);
            end
            FWS_SEL_ADDR_HI: begin
               if (i_pstrb[0]) begin
                  addr_hi_d = i_pwdata[`FWS_ADDR_HI_W-1:0];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         even_lo_q <= `FWS_RST_DATA;
         even_hi_q <= `FWS_RST_DATA;
         odd_lo_q  <= `FWS_RST_DATA;
         odd_hi_q  <= `FWS_RST_DATA;
         addr_lo_q <= `FWS_RST_ADDR_LO;
         addr_hi_q <= `FWS_RST_ADDR_HI;
      end else begin
         even_lo_q <= even_lo_d;
         even_hi_q <= even_hi_d;
         odd_lo_q  <= odd_lo_d;
         odd_hi_q  <= odd_hi_d;
         addr_lo_q <= addr_lo_d;
         addr_hi_q <= addr_hi_d;
      end
   end

   // ****************************************
   // Interrupt status, enable and clear
   // ****************************************
   always_comb begin
      irq_events = '0;
      irq_events[`FWS_IRQ_DONE] = ev_done;
      irq_events[`FWS_IRQ_FAIL] = ev_fail;
      irq_events[`FWS_IRQ_SUSPEND_FLAG] = ev_suspend_flag;
      irq_stat_d = irq_stat_q;
      irq_en_d   = irq_en_q;
      if (access_wr && (sel == FWS_SEL_IRQ_CLEAR) && i_pstrb[0]) begin
         irq_stat_d = irq_stat_q & ~i_pwdata[`FWS_IRQ_W-1:0];
      end
      if (access_wr && (sel == FWS_SEL_IRQ_ENABLE) && i_pstrb[0]) begin
         irq_en_d = i_pwdata[`FWS_IRQ_W-1:0];
      end
      // A new event wins over a clear in the same cycle
      irq_stat_d = irq_stat_d | irq_events;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         irq_stat_q <= `FWS_RST_IRQ;
         irq_en_q   <= `FWS_RST_IRQ;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq_en_q   <= irq_en_d;
      end
   end

   assign o_irq = |(irq_stat_q & irq_en_q);

   // ****************************************
   // Read data, captured in the setup cycle
   // ****************************************
   always_comb begin
      prdata_d = prdata_q;
      if (setup_rd) begin
         unique case (sel)
            FWS_SEL_SECTOR:       prdata_d = word16({8'h00, sector_flags});
            FWS_SEL_BANK:         prdata_d = word16(16'(bank_flag) << `FWS_BANK_FLAG_BIT);
            FWS_SEL_DATA_EVEN_LO: prdata_d = word16(even_lo_q);
            FWS_SEL_DATA_EVEN_HI: prdata_d = word16(even_hi_q);
            FWS_SEL_DATA_ODD_LO:  prdata_d = word16(odd_lo_q);
            FWS_SEL_DATA_ODD_HI:  prdata_d = word16(odd_hi_q);
            FWS_SEL_ADDR_LO:      prdata_d = word16({addr_lo_q, 2'b00});
            FWS_SEL_ADDR_HI:      prdata_d = word16({11'h000, addr_hi_q});
            FWS_SEL_IRQ_STATUS:   prdata_d = word16({13'h0000, irq_stat_q});
            FWS_SEL_IRQ_ENABLE:   prdata_d = word16({13'h0000, irq_en_q});
            default:              prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   assign o_prdata = prdata_q;

   // ****************************************
   // Outputs to the write controller
   // ****************************************
   // erase only selected sectors
   assign o_sector_select = sector_flags;
   assign o_bank_flag     = bank_flag;
   assign o_data_even     = {even_hi_q, even_lo_q};
   assign o_data_odd      = {odd_hi_q, odd_lo_q};
   assign o_target_addr   = {addr_hi_q, addr_lo_q, 2'b00};

   assign o_erase_error     = (meaning == FWS_FLAG_ERROR) && (bank_flag || (|sector_flags));
   assign o_erase_suspended = (meaning == FWS_FLAG_SUSPENDED)
                              && (bank_flag || (|sector_flags));

endmodule // fws_top

// ---- fws_top_asserts.sv ----
`timescale 1ns/1ns
`include "fws_params.svh"

module fws_top_chk
   import fws_pkg::*;
(
   input wire logic                    i_clk_sys,
   input wire logic                    i_rst,
   input wire logic [`FWS_APB_AW-1:0]  i_paddr,
   input wire logic                    i_psel,
   input wire logic                    i_penable,
   input wire logic                    i_pwrite,
   input wire logic [31:0]             i_pwdata,
   input wire logic [3:0]              i_pstrb,
   input wire logic                    i_write_busy,
   input wire logic                    i_erase_op,
   input wire logic                    i_err_flag,
   input wire logic                    i_suspend_flag_flag,
   input wire logic [`FWS_SECTORS-1:0] i_hw_sector,
   input wire logic                    i_hw_bank,
   input wire logic [`FWS_SECTORS-1:0] o_sector_select,
   input wire logic                    o_bank_flag,
   input wire logic [31:0]             o_data_even,
   input wire logic [31:0]             o_data_odd,
   input wire logic [`FWS_TARGET_W-1:0] o_target_addr,
   input wire logic                    o_erase_error,
   input wire logic                    o_erase_suspended,
   input wire logic                    o_irq
);
   // ****************************************
   // Phase of the controller seen from the ports
   // ****************************************
   fws_phase_e ph_q, ph_d;
   logic       wr_acc;
   assign wr_acc = i_psel && i_penable && i_pwrite;
   always_comb begin
      ph_d = ph_q;
      if (ph_q == FWS_PH_IDLE && i_write_busy) ph_d = i_erase_op ? FWS_PH_ERASE : FWS_PH_WRITE;
      else if (ph_q != FWS_PH_IDLE && !i_write_busy) ph_d = FWS_PH_IDLE;
   end
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) ph_q <= FWS_PH_IDLE;
      else ph_q <= ph_d;
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   a_sector_follow:
      assert property (ph_q == FWS_PH_ERASE && i_write_busy |=> o_sector_select == $past(i_hw_sector))
      else $error("Sector flags do not follow the controller");
   a_bank_follow:
      assert property (ph_q == FWS_PH_ERASE && i_write_busy |=> o_bank_flag == $past(i_hw_bank))
      else $error("Bank flag does not follow the controller");
   a_sector_clear_ok:
      assert property (ph_q != FWS_PH_IDLE && !i_write_busy && !i_err_flag && !i_suspend_flag_flag
                       |=> o_sector_select == 8'h00)
      else $error("Sector flags not cleared after clean end");
   a_bank_clear_ok:
      assert property (ph_q == FWS_PH_ERASE && !i_write_busy && !i_err_flag && !i_suspend_flag_flag
                       |=> !o_bank_flag)
      else $error("Bank flag not cleared after clean erase end");
   a_meaning_excl:
      assert property (!(o_erase_error && o_erase_suspended))
      else $error("Error and suspended shown together");
   a_meaning_flag:
      assert property (o_erase_error || o_erase_suspended |-> (|o_sector_select) || o_bank_flag)
      else $error("Meaning shown with no flag set");
   a_data_hold:
      assert property (!wr_acc |=> $stable(o_data_even) && $stable(o_data_odd)
                       && $stable(o_target_addr))
      else $error("Data or address changed without a write");
   a_addr_lo_write:
      assert property (wr_acc && i_pstrb[1:0] == 2'b11 && i_paddr == {`FWS_IDX_ADDR_LO, 2'b00}
                       |=> o_target_addr[15:2] == $past(i_pwdata[15:2]))
      else $error("Low address write not taken");
   a_addr_lsb_zero:
      assert property (o_target_addr[1:0] == 2'b00)
      else $error("Reserved address bits not zero");

   c_error: cover property (o_erase_error);
   c_suspend_flag: cover property (o_erase_suspended);
   c_irq: cover property ($rose(o_irq));
endmodule // fws_top_chk

bind fws_top fws_top_chk u_chk (.*);

// ---- fws_top_tb.sv ----
`timescale 1ns/1ns
`include "fws_params.svh"

module fws_top_tb;
   logic        i_clk_sys = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
   logic [23:0] i_paddr = 24'h000000;
   logic [31:0] i_pwdata = 32'h00000000;
   logic        i_write_busy = 1'b0, i_erase_op = 1'b0, i_err_flag = 1'b0, i_suspend_flag_flag = 1'b0;
   logic        i_hw_bank = 1'b0;
   logic [7:0]  i_hw_sector = 8'h00, o_sector_select;
   logic [31:0] o_prdata, o_data_even, o_data_odd, rd;
   logic        o_pready, o_pslverr, o_bank_flag, o_erase_error, o_erase_suspended, o_irq, err;
   logic [20:0] o_target_addr;
   int          n_mismatch = 0, cmp_count = 0, cycles = 0;
   logic [21:0] ridx [10] = '{`FWS_IDX_DATA_EVEN_LO, `FWS_IDX_DATA_EVEN_HI, `FWS_IDX_DATA_ODD_LO,
      `FWS_IDX_DATA_ODD_HI, `FWS_IDX_ADDR_LO, `FWS_IDX_ADDR_HI, `FWS_IDX_SECTOR, `FWS_IDX_BANK,
      `FWS_IDX_IRQ_STATUS, `FWS_IDX_IRQ_ENABLE};
   logic [31:0] rexp [10] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF,
      32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

   fws_top u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_paddr(i_paddr), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .i_pstrb(4'hF),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .i_write_busy(i_write_busy), .i_erase_op(i_erase_op), .i_err_flag(i_err_flag),
      .i_suspend_flag_flag(i_suspend_flag_flag), .i_hw_sector(i_hw_sector), .i_hw_bank(i_hw_bank),
      .o_sector_select(o_sector_select), .o_bank_flag(o_bank_flag), .o_data_even(o_data_even),
      .o_data_odd(o_data_odd), .o_target_addr(o_target_addr), .o_erase_error(o_erase_error),
      .o_erase_suspended(o_erase_suspended), .o_irq(o_irq));

   // ****************************************
   // Clock, timeout and helpers
   // ****************************************
   initial begin
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 4000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   // One APB transfer; answer taken at the pready edge
   task automatic apb(input logic wr, input logic [23:0] a, input logic [15:0] d);
      @(posedge i_clk_sys);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= {16'h0000, d};
      @(posedge i_clk_sys);
      i_penable <= 1'b1;
      do @(posedge i_clk_sys); while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      #1;
   endtask
   task automatic wr(input logic [21:0] idx, input logic [15:0] d);
      apb(1'b1, {idx, 2'b00}, d);
   endtask
   task automatic rdc(input string nm, input logic [21:0] idx, input logic [31:0] exp);
      apb(1'b0, {idx, 2'b00}, 16'h0000);
      chk(nm, rd, exp);
   endtask
   task automatic op_start(input logic e, input logic [7:0] sec, input logic bank);
      @(posedge i_clk_sys);
      i_erase_op <= e;
      i_hw_sector <= sec;
      i_hw_bank <= bank;
      i_err_flag <= 1'b0;
      i_suspend_flag_flag <= 1'b0;
      i_write_busy <= 1'b1;
      cyc(3);
   endtask
   task automatic op_end(input logic er, input logic su);
      @(posedge i_clk_sys);
      i_err_flag <= er;
      i_suspend_flag_flag <= su;
      i_write_busy <= 1'b0;
      cyc(3);
   endtask
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (5) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      for (int k = 0; k < 10; k++) rdc("reset value", ridx[k], rexp[k]);
      $display("Test reset values done");
      wr(`FWS_IDX_DATA_EVEN_LO, 16'h1234);
      wr(`FWS_IDX_DATA_EVEN_HI, 16'hABCD);
      wr(`FWS_IDX_DATA_ODD_LO, 16'h5678);
      wr(`FWS_IDX_DATA_ODD_HI, 16'h9ABC);
      wr(`FWS_IDX_ADDR_LO, 16'hFFFB);
      wr(`FWS_IDX_ADDR_HI, 16'hFFFF);
      chk("data even", o_data_even, 32'hABCD1234);
      chk("data odd", o_data_odd, 32'h9ABC5678);
      chk("target", 32'(o_target_addr), 32'h1FFFF8);
      rdc("addr lo", `FWS_IDX_ADDR_LO, 32'hFFF8);
      $display("Test data and address done");
      wr(`FWS_IDX_SECTOR, 16'h00A5);
      chk("select", 32'(o_sector_select), 32'hA5);
      op_start(1'b1, 8'h3C, 1'b1);
      chk("erase sectors", 32'(o_sector_select), 32'h3C);
      rdc("bank busy", `FWS_IDX_BANK, 32'h100);
      wr(`FWS_IDX_SECTOR, 16'h0055);
      chk("sector wr in erase", 32'(o_sector_select), 32'h3C);
      op_end(1'b0, 1'b0);
      chk("sectors clean", 32'(o_sector_select), 32'h0);
      chk("bank clean", 32'(o_bank_flag), 32'h0);
      chk("irq masked", 32'(o_irq), 32'h0);
      rdc("status done", `FWS_IDX_IRQ_STATUS, 32'h1);
      wr(`FWS_IDX_IRQ_ENABLE, 16'h0007);
      chk("irq on", 32'(o_irq), 32'h1);
      wr(`FWS_IDX_IRQ_CLEAR, 16'h0001);
      chk("irq off", 32'(o_irq), 32'h0);
      $display("Test clean erase done");
      op_start(1'b1, 8'hF0, 1'b1);
      op_end(1'b1, 1'b0);
      chk("err sectors", 32'(o_sector_select), 32'hF0);
      chk("err bank", 32'(o_bank_flag), 32'h1);
      chk("erase error", 32'({o_erase_error, o_erase_suspended}), 32'h2);
      rdc("status fail", `FWS_IDX_IRQ_STATUS, 32'h2);
      wr(`FWS_IDX_IRQ_CLEAR, 16'h0002);
      op_start(1'b1, 8'h0F, 1'b1);
      op_end(1'b0, 1'b1);
      chk("suspend_flag sectors", 32'(o_sector_select), 32'h0F);
      chk("erase suspend_flag", 32'({o_erase_error, o_erase_suspended}), 32'h1);
      rdc("status suspend_flag", `FWS_IDX_IRQ_STATUS, 32'h4);
      wr(`FWS_IDX_IRQ_CLEAR, 16'h0004);
      chk("irq cleared", 32'(o_irq), 32'h0);
      $display("Test erase error and suspend done");
      wr(`FWS_IDX_SECTOR, 16'h0081);
      op_start(1'b0, 8'h66, 1'b0);
      op_end(1'b0, 1'b0);
      chk("prog sectors", 32'(o_sector_select), 32'h0);
      chk("prog bank kept", 32'(o_bank_flag), 32'h1);
      rdc("status prog", `FWS_IDX_IRQ_STATUS, 32'h1);
      $display("Test program end done");
      apb(1'b0, 24'h000004, 16'h0000);
      chk("unmapped", {rd[30:0], err}, 32'h1);
      apb(1'b0, {`FWS_IDX_DATA_ODD_LO, 2'b10}, 16'h0000);
      chk("misaligned err", 32'(err), 32'h1);
      wr(`FWS_IDX_BANK, 16'h0000);
      rdc("bank read only", `FWS_IDX_BANK, 32'h100);
      chk("data kept", o_data_even, 32'hABCD1234);
      $display("Test refusals done");
      complete_run();
   end
endmodule // fws_top_tb
